// file: logic/emscr_pkg.sv
// Purpose: Constants and types shared by the system configuration register bank
// Assumes: 32-bit APB, byte addresses equal printed offsets
// Notes: Every offset, field position and register reset value lives here; the virtual-wire bits reset to zero in the gate
package emscr_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_WDT_FIRE = 8'h28;
    localparam logic [7:0] ADDR_VREF_DIS = 8'h40;
    localparam logic [7:0] ADDR_SHDN_OVR = 8'h50;
    localparam logic [7:0] ADDR_BANK_LVL = 8'h64;
    localparam logic [7:0] ADDR_VW_SEL = 8'h90;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CNT_W = 4;
    localparam int BIT_LOCK = 7;
    localparam int BIT_LVL3 = 2;
    localparam int BIT_LVL2 = 1;
    localparam int BIT_TEST = 0;
    localparam int BIT_SEL_SMI = 1;
    localparam int BIT_SEL_SCI = 0;
    localparam int BIT_VREF_DIS = 0;
    localparam int BIT_SHDN_OVR = 0;
    localparam logic RST_BANK_BIT = 1'h0;
    localparam int SEL_W = 3;
    localparam logic [3:0] RST_WDT_FIRE = 4'h0;
    localparam logic RST_VREF_DIS = 1'h0;
    localparam logic RST_SHDN_OVR = 1'h1;
    localparam logic [SEL_W-1:0] RST_VW_SEL = 3'h7;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } emscr_apb_req_t;

    // Hardware and firmware requests towards the virtual-wire bits
    typedef struct packed {
        logic smi_hw;
        logic sci_hw;
        logic smi_fw_we;
        logic smi_fw_val;
        logic sci_fw_we;
        logic sci_fw_val;
    } emscr_vw_req_t;

endpackage

// file: logic/emscr_vwire_gate.sv
// Purpose: Merges gated hardware sources and firmware writes onto two virtual-wire bits
// Assumes: Hardware sources are levels synchronous to the clock
// Notes: Firmware write wins over a hardware level in the same cycle
module emscr_vwire_gate
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic [emscr_pkg::SEL_W-1:0] sel_in,
    input wire emscr_pkg::emscr_vw_req_t req_in,
    // Result
    output logic smi_out,
    output logic sci_out
);
    wire smi_hw_en = ~sel_in[emscr_pkg::BIT_SEL_SMI];
    wire sci_hw_en = ~sel_in[emscr_pkg::BIT_SEL_SCI];
    // Firmware write always lands regardless of selector
    wire next_smi = req_in.smi_fw_we ? req_in.smi_fw_val
                  : (smi_hw_en ? req_in.smi_hw : smi_out);
    wire next_sci = req_in.sci_fw_we ? req_in.sci_fw_val
                  : (sci_hw_en ? req_in.sci_hw : sci_out);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            smi_out <= 1'h0;
            sci_out <= 1'h0;
        end
        else
        begin
            smi_out <= next_smi;
            sci_out <= next_sci;
        end
    end
endmodule // emscr_vwire_gate

// file: logic/emscr_regs.sv
// Purpose: Miscellaneous system configuration register bank on APB
// Assumes: Power-on reset on resetn_in, watchdog-triggered reset on wdt_resetn_in
// Notes: Zero-wait-state slave; unmapped addresses read zero, no error
//
// Summary of operation
// - Watchdog fire count clears on power-on reset, survives watchdog reset.
// - Vref disable bit one turns off reference pin; resets to zero.
// - Shutdown override resets to one; firmware drives it to drop battery output.
// - Bank lock bit, once set, freezes level bits and itself until reset.
// - Level bits 2 and 1 select 1.8V at one, 3.3V at zero.
// - Selector bit 1 zero lets mailbox SMI source drive virtual wire.
// - Selector bit 0 zero lets controller SCI source drive virtual wire.
// - Firmware writes to virtual-wire source bits always take effect.
module emscr_regs
(
    // Clock and resets
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic wdt_resetn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Virtual-wire sources and firmware writes
    input wire logic mailbox_host_smi_source_in,
    input wire logic controller_sci_source_in,
    input wire logic vwire_smi_fw_we_in,
    input wire logic vwire_smi_fw_val_in,
    input wire logic vwire_sci_fw_we_in,
    input wire logic vwire_sci_fw_val_in,
    // Controls to the chip
    output logic cpu_vref_disable_out,
    output logic firmware_shutdown_override_out,
    output logic bank3_supply_level_out,
    output logic bank2_supply_level_out,
    output logic bank_test_out,
    output logic vwire_smi_bit_out,
    output logic vwire_sci_bit_out
);
    // ----------------------------------------------------------------
    // Reset synchronisers
    // ----------------------------------------------------------------
    logic por_meta, por_n, wdt_meta, sys_n;
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            por_meta <= 1'h0;
            por_n <= 1'h0;
        end
        else
        begin
            por_meta <= 1'h1;
            por_n <= por_meta;
        end
    end

    // System reset: power-on or watchdog
    wire sys_rst_raw_n = resetn_in & wdt_resetn_in;
    always_ff @(posedge sys_clk_in or negedge sys_rst_raw_n)
    begin
        if (!sys_rst_raw_n)
        begin
            wdt_meta <= 1'h0;
            sys_n <= 1'h0;
        end
        else
        begin
            wdt_meta <= 1'h1;
            sys_n <= wdt_meta;
        end
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire wr = psel_in & penable_in & pwrite_in;
    wire hit_wdt = (paddr_in == emscr_pkg::ADDR_WDT_FIRE);
    wire hit_vref = (paddr_in == emscr_pkg::ADDR_VREF_DIS);
    wire hit_shdn = (paddr_in == emscr_pkg::ADDR_SHDN_OVR);
    wire hit_lvl = (paddr_in == emscr_pkg::ADDR_BANK_LVL);
    wire hit_vw = (paddr_in == emscr_pkg::ADDR_VW_SEL);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [emscr_pkg::CNT_W-1:0] watchdog_fire_count;
    logic bank_lock;
    logic [emscr_pkg::SEL_W-1:0] vwire_hw_source_select;

    // Counter sits only on the power-on reset so a watchdog bite keeps it
    always_ff @(posedge sys_clk_in or negedge por_n)
    begin
        if (!por_n)
            watchdog_fire_count <= emscr_pkg::RST_WDT_FIRE;
        else if (wr && hit_wdt)
            watchdog_fire_count <= pwdata_in[emscr_pkg::CNT_W-1:0];
    end

    wire lvl_we = wr & hit_lvl & ~bank_lock;

    always_ff @(posedge sys_clk_in or negedge sys_n)
    begin
        if (!sys_n)
        begin
            cpu_vref_disable_out <= emscr_pkg::RST_VREF_DIS;
            firmware_shutdown_override_out <= emscr_pkg::RST_SHDN_OVR;
            bank_lock <= emscr_pkg::RST_BANK_BIT;
            bank3_supply_level_out <= emscr_pkg::RST_BANK_BIT;
            bank2_supply_level_out <= emscr_pkg::RST_BANK_BIT;
            bank_test_out <= emscr_pkg::RST_BANK_BIT;
            vwire_hw_source_select <= emscr_pkg::RST_VW_SEL;
        end
        else
        begin
            if (wr && hit_vref)
                cpu_vref_disable_out <= pwdata_in[emscr_pkg::BIT_VREF_DIS];
            if (wr && hit_shdn)
                firmware_shutdown_override_out <= pwdata_in[emscr_pkg::BIT_SHDN_OVR];
            if (lvl_we)
            begin
                // Lock only sets; a zero write leaves it alone
                bank_lock <= pwdata_in[emscr_pkg::BIT_LOCK];
                bank3_supply_level_out <= pwdata_in[emscr_pkg::BIT_LVL3];
                bank2_supply_level_out <= pwdata_in[emscr_pkg::BIT_LVL2];
            end
            // Test bit stays writable under the lock
            if (wr && hit_lvl)
                bank_test_out <= pwdata_in[emscr_pkg::BIT_TEST];
            if (wr && hit_vw)
                vwire_hw_source_select <= pwdata_in[emscr_pkg::SEL_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Virtual-wire merge
    // ----------------------------------------------------------------
    emscr_pkg::emscr_vw_req_t vw_req;
    assign vw_req = '{smi_hw: mailbox_host_smi_source_in,
                      sci_hw: controller_sci_source_in,
                      smi_fw_we: vwire_smi_fw_we_in,
                      smi_fw_val: vwire_smi_fw_val_in,
                      sci_fw_we: vwire_sci_fw_we_in,
                      sci_fw_val: vwire_sci_fw_val_in};

    emscr_vwire_gate u_gate
    (
        .clk_in(sys_clk_in),
        .rst_n_in(sys_n),
        .sel_in(vwire_hw_source_select),
        .req_in(vw_req),
        .smi_out(vwire_smi_bit_out),
        .sci_out(vwire_sci_bit_out)
    );

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        if (hit_wdt)
            rd_mux[emscr_pkg::CNT_W-1:0] = watchdog_fire_count;
        if (hit_vref)
            rd_mux[emscr_pkg::BIT_VREF_DIS] = cpu_vref_disable_out;
        if (hit_shdn)
            rd_mux[emscr_pkg::BIT_SHDN_OVR] = firmware_shutdown_override_out;
        if (hit_lvl)
        begin
            rd_mux[emscr_pkg::BIT_LOCK] = bank_lock;
            rd_mux[emscr_pkg::BIT_LVL3] = bank3_supply_level_out;
            rd_mux[emscr_pkg::BIT_LVL2] = bank2_supply_level_out;
            rd_mux[emscr_pkg::BIT_TEST] = bank_test_out;
        end
        if (hit_vw)
            rd_mux[emscr_pkg::SEL_W-1:0] = vwire_hw_source_select;
    end

    // Ready registered from the setup cycle rises in the access cycle, giving a single access cycle
    always_ff @(posedge sys_clk_in or negedge sys_n)
    begin
        if (!sys_n)
        begin
            prdata_out <= 32'h0;
            pready_out <= 1'h0;
            pslverr_out <= 1'h0;
        end
        else
        begin
            pready_out <= psel_in & ~penable_in;
            pslverr_out <= 1'h0;
            if (psel_in && !penable_in && !pwrite_in)
                prdata_out <= rd_mux;
        end
    end
endmodule // emscr_regs

// file: dv/emscr_regs_monitor.sv
// Purpose: Port assertions for the configuration register bank
// Assumes: One clock, both resets active low
// Notes: Selector and lock are internal, so they are judged at outputs
module emscr_regs_monitor
(
    // Clock and resets
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic wdt_resetn_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    // Virtual wire and controls
    input wire logic mailbox_host_smi_source_in,
    input wire logic controller_sci_source_in,
    input wire logic vwire_smi_fw_we_in,
    input wire logic vwire_smi_fw_val_in,
    input wire logic vwire_sci_fw_we_in,
    input wire logic cpu_vref_disable_out,
    input wire logic firmware_shutdown_override_out,
    input wire logic bank3_supply_level_out,
    input wire logic bank2_supply_level_out,
    input wire logic bank_test_out,
    input wire logic vwire_smi_bit_out,
    input wire logic vwire_sci_bit_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in || !wdt_resetn_in);
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence wr_s(logic [7:0] a);
        psel_in && penable_in && pwrite_in && paddr_in == a;
    endsequence
    // Lock is internal, so it is learnt from a read of the bank register
    logic lock_seen;
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in || !wdt_resetn_in)
            lock_seen <= 1'h0;
        else if (pready_out && psel_in && !pwrite_in && paddr_in == 8'h64 && prdata_out[7])
            lock_seen <= 1'h1;
    end
    ready_next_a: assert property (setup_s |=> pready_out)
        else $error("no ready after setup");
    vref_write_a: assert property (
        wr_s(8'h40) |=> cpu_vref_disable_out == $past(pwdata_in[0]))
        else $error("vref bit wrong");
    shdn_write_a: assert property (
        wr_s(8'h50) |=> firmware_shutdown_override_out == $past(pwdata_in[0]))
        else $error("override bit wrong");
    level_hold_a: assert property (
        !(psel_in && penable_in && pwrite_in && paddr_in == 8'h64)
        |=> $stable({bank3_supply_level_out, bank2_supply_level_out, bank_test_out}))
        else $error("levels moved");
    lock_hold_a: assert property (
        lock_seen ##0 wr_s(8'h64) |=> $stable({bank3_supply_level_out, bank2_supply_level_out}))
        else $error("locked levels moved");
    smi_source_a: assert property (
        $changed(vwire_smi_bit_out) && !$past(vwire_smi_fw_we_in)
        |-> vwire_smi_bit_out == $past(mailbox_host_smi_source_in)) else $error("smi bit wrong");
    sci_source_a: assert property (
        $changed(vwire_sci_bit_out) && !$past(vwire_sci_fw_we_in)
        |-> vwire_sci_bit_out == $past(controller_sci_source_in)) else $error("sci bit wrong");
    fw_write_a: assert property (
        vwire_smi_fw_we_in |=> vwire_smi_bit_out == $past(vwire_smi_fw_val_in))
        else $error("firmware write lost");
    reserved_zero_a: assert property (
        pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0)
        else $error("reserved bits set");
endmodule // emscr_regs_monitor

bind emscr_regs emscr_regs_monitor mon
(
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wdt_resetn_in(wdt_resetn_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .mailbox_host_smi_source_in(mailbox_host_smi_source_in),
    .controller_sci_source_in(controller_sci_source_in),
    .vwire_smi_fw_we_in(vwire_smi_fw_we_in),
    .vwire_smi_fw_val_in(vwire_smi_fw_val_in),
    .vwire_sci_fw_we_in(vwire_sci_fw_we_in),
    .cpu_vref_disable_out(cpu_vref_disable_out),
    .firmware_shutdown_override_out(firmware_shutdown_override_out),
    .bank3_supply_level_out(bank3_supply_level_out),
    .bank2_supply_level_out(bank2_supply_level_out),
    .bank_test_out(bank_test_out),
    .vwire_smi_bit_out(vwire_smi_bit_out),
    .vwire_sci_bit_out(vwire_sci_bit_out)
);

// file: dv/ec_misc_system_config_regs_tb.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Zero-wait APB slave, 100 ns clock
// Notes: Bench drives every port itself
module ec_misc_system_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'h0, resetn_in = 1'h0, wdt_resetn_in = 1'h1;
    logic psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
    logic [7:0] paddr_in = 8'h0;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic pready_out, pslverr_out, cpu_vref_disable_out, firmware_shutdown_override_out;
    logic mailbox_host_smi_source_in = 1'h0, controller_sci_source_in = 1'h0;
    logic vwire_smi_fw_we_in = 1'h0, vwire_smi_fw_val_in = 1'h0;
    logic vwire_sci_fw_we_in = 1'h0, vwire_sci_fw_val_in = 1'h0;
    logic bank3_supply_level_out, bank2_supply_level_out, bank_test_out;
    logic vwire_smi_bit_out, vwire_sci_bit_out;
    int n_errors = 0, checks = 0, cyc = 0;
`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("wrong value at %0t: %h, expected %h", $time, g, e); \
        end \
    end
    emscr_regs dut
    (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .wdt_resetn_in(wdt_resetn_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .mailbox_host_smi_source_in(mailbox_host_smi_source_in),
        .controller_sci_source_in(controller_sci_source_in),
        .vwire_smi_fw_we_in(vwire_smi_fw_we_in),
        .vwire_smi_fw_val_in(vwire_smi_fw_val_in),
        .vwire_sci_fw_we_in(vwire_sci_fw_we_in),
        .vwire_sci_fw_val_in(vwire_sci_fw_val_in),
        .cpu_vref_disable_out(cpu_vref_disable_out),
        .firmware_shutdown_override_out(firmware_shutdown_override_out),
        .bank3_supply_level_out(bank3_supply_level_out),
        .bank2_supply_level_out(bank2_supply_level_out),
        .bank_test_out(bank_test_out),
        .vwire_smi_bit_out(vwire_smi_bit_out),
        .vwire_sci_bit_out(vwire_sci_bit_out)
    );
    always #50 sys_clk_in = ~sys_clk_in;
    // Run needs about 90 cycles
    always @(posedge sys_clk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'h1;
        @(posedge sys_clk_in);
        while (pready_out !== 1'h1)
            @(posedge sys_clk_in);
        r = prdata_out;
        `CHK(pslverr_out, 1'h0)
        psel_in <= 1'h0;
        penable_in <= 1'h0;
        @(posedge sys_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'h1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'h0, a, 32'h0, r);
        `CHK(r, e)
    endtask
    task automatic rst(input logic wdt, input int hold);
        if (wdt)
            wdt_resetn_in <= 1'h0;
        else
            resetn_in <= 1'h0;
        repeat (hold) @(posedge sys_clk_in);
        wdt_resetn_in <= 1'h1;
        resetn_in <= 1'h1;
        repeat (3) @(posedge sys_clk_in);
    endtask
    task automatic fw(input logic v);
        vwire_smi_fw_we_in <= 1'h1;
        vwire_smi_fw_val_in <= v;
        vwire_sci_fw_we_in <= 1'h1;
        vwire_sci_fw_val_in <= v;
        @(posedge sys_clk_in);
        vwire_smi_fw_we_in <= 1'h0;
        vwire_sci_fw_we_in <= 1'h0;
        @(negedge sys_clk_in);
        `CHK({vwire_smi_bit_out, vwire_sci_bit_out}, {v, v})
        @(posedge sys_clk_in);
    endtask
    task automatic t_defaults();
        rd(8'h28, 32'h0);
        rd(8'h40, 32'h0);
        rd(8'h50, 32'h1);
        rd(8'h64, 32'h0);
        rd(8'h90, 32'h7);
        rd(8'h30, 32'h0);
        wr(8'h40, 32'hffffffff);
        `CHK(cpu_vref_disable_out, 1'h1)
        rd(8'h40, 32'h1);
        wr(8'h50, 32'h0);
        `CHK(firmware_shutdown_override_out, 1'h0)
    endtask
    task automatic t_lock();
        wr(8'h64, 32'h6);
        `CHK({bank3_supply_level_out, bank2_supply_level_out}, 2'h3)
        wr(8'h64, 32'h0);
        `CHK({bank3_supply_level_out, bank2_supply_level_out}, 2'h0)
        wr(8'h64, 32'hff84);
        wr(8'h64, 32'h3);
        rd(8'h64, 32'h85);
        `CHK({bank3_supply_level_out, bank2_supply_level_out, bank_test_out}, 3'h5)
        wr(8'h64, 32'h80);
        `CHK({bank3_supply_level_out, bank2_supply_level_out, bank_test_out}, 3'h4)
    endtask
    task automatic t_wdt();
        wr(8'h28, 32'hfffffffa);
        rd(8'h28, 32'ha);
        rst(1'h1, 2);
        rd(8'h28, 32'ha);
        rd(8'h64, 32'h0);
        `CHK(firmware_shutdown_override_out, 1'h1)
        `CHK(cpu_vref_disable_out, 1'h0)
        rst(1'h0, 2);
        rd(8'h28, 32'h0);
    endtask
    task automatic t_vwire();
        mailbox_host_smi_source_in <= 1'h1;
        controller_sci_source_in <= 1'h1;
        repeat (2) @(posedge sys_clk_in);
        `CHK({vwire_smi_bit_out, vwire_sci_bit_out}, 2'h0)
        fw(1'h1);
        fw(1'h0);
        wr(8'h90, 32'h6);
        @(posedge sys_clk_in);
        `CHK({vwire_smi_bit_out, vwire_sci_bit_out}, 2'h1)
        wr(8'h90, 32'h4);
        @(posedge sys_clk_in);
        `CHK({vwire_smi_bit_out, vwire_sci_bit_out}, 2'h3)
        // An enabled source is a level, so the bit must follow it down
        mailbox_host_smi_source_in <= 1'h0;
        repeat (2) @(posedge sys_clk_in);
        `CHK(vwire_smi_bit_out, 1'h0)
        // Firmware must still win while both hardware sources are enabled
        fw(1'h0);
    endtask
    initial
    begin
        rst(1'h0, 4);
        t_defaults();
        t_lock();
        t_wdt();
        t_vwire();
        stop_test();
    end
endmodule // ec_misc_system_config_regs_tb
